/* File: fmag_ctrl.v */
// Ferroelectric array access controller with region guard and
// boot loader gating. APB register slave, core memory port.
// Assumes core holds CORE_REQ and its fields until CORE_READY.
//
// Function
// - No waits at or below array limit; wait states when clock is faster.
// - Reads and writes need no erase, setup or unlock; guard may refuse.
// - Every bit writable alone through a bit mask, no block erase.
// - Every sensing read is followed by a restore write of the sensed word, with masked bits replaced on writes.
// - A started restore write always finishes; power fail never aborts it.
// - Writes into read-only segments are suppressed and flagged.
// - Three classes read-only, read-write, read-execute; bounds movable live.
// - Segment bounds are 4 KB block indices, not byte addresses.
// - Boot loader window is never written; attempts are refused and flagged.
// - Disable signature at its location keeps the boot loader from entering.
// - Boot loader uses only the interface strapped at manufacture.
//
// The implementer's own choices: the APB register port and the address map.
`include "fmag_defines.vh"
module fmag_ctrl #(
    parameter CLK_KHZ   = `FMAG_CLK_KHZ,
    parameter ARRAY_KHZ = `FMAG_ARRAY_KHZ,
    parameter ADDR_W    = 16,
    parameter DATA_W    = 16
) (
    // Clock and reset
    input  wire              MCLK,
    input  wire              RSTN,
    // APB register slave
    input  wire              PSEL,
    input  wire              PENABLE,
    input  wire              PWRITE,
    input  wire [7:0]        PADDR,
    input  wire [31:0]       PWDATA,
    output wire [31:0]       PRDATA,
    output wire              PREADY,
    output wire              PSLVERR,
    // Core memory port
    input  wire              CORE_REQ,
    input  wire              CORE_WE,
    input  wire              CORE_FETCH,
    input  wire [ADDR_W-1:0] CORE_ADDR,
    input  wire [DATA_W-1:0] CORE_WDATA,
    input  wire [DATA_W-1:0] CORE_WMASK,
    output wire [DATA_W-1:0] CORE_RDATA,
    output wire              CORE_READY,
    output wire              CORE_ERR,
    // System
    input  wire              POWER_FAIL,
    input  wire              BOOT_ENTRY,
    input  wire              BOOT_IF_I2C,
    output wire              BOOT_ACTIVE,
    output wire              BOOT_UART_EN,
    output wire              BOOT_I2C_EN
);
    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_WAIT    = 3'h1;
    localparam [2:0] ST_SENSE   = 3'h2;
    localparam [2:0] ST_RESTORE = 3'h3;

    localparam integer WAIT_MIN = (CLK_KHZ > ARRAY_KHZ) ?
        ((CLK_KHZ + ARRAY_KHZ - 1) / ARRAY_KHZ - 1) : 0;
    localparam [2:0] WAIT_MIN3 = WAIT_MIN[2:0];
    localparam integer WA = ADDR_W - 1;

    // Larger of programmed and minimum wait count
    function [2:0] fmag_max3;
        input [2:0] a;
        input [2:0] b;
        begin
            fmag_max3 = (a > b) ? a : b;
        end
    endfunction

    // Register state
    reg [2:0]        state_reg;
    reg [2:0]        wcnt_reg;
    reg [2:0]        wait_reg;
    reg [3:0]        bound1_reg;
    reg [3:0]        bound2_reg;
    reg [5:0]        class_reg;
    reg              gen_reg;
    reg [4:0]        flag_reg;
    reg [31:0]       prdata_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] wdata_reg;
    reg [DATA_W-1:0] wmask_reg;
    reg [DATA_W-1:0] rdata_reg;
    reg              ready_reg;
    reg              err_reg;
    reg              sig_pend_reg;
    reg              boot_req_reg;
    reg              boot_skip_reg;
    reg              i2c_reg;
    reg              pfail_reg;

    reg [4:0]        flag_next;
    reg [31:0]       rd_mux;

    wire [2:0]        wait_eff;
    wire [DATA_W-1:0] mem_rdata;
    wire [DATA_W-1:0] merged;
    wire              g_allow;
    wire [1:0]        g_seg;
    wire              g_boot;
    wire              take;
    wire              apb_wr;
    wire              apb_setup_rd;
    wire              mapped;
    wire              key_ok;

    // Effective waits never fall below what the clock ratio demands
    assign wait_eff = fmag_max3(wait_reg, WAIT_MIN3);

    // Bit-granular merge of new data over the sensed word
    assign merged = (mem_rdata & ~wmask_reg) |
                    (wdata_reg & wmask_reg);

    // No new access starts during power fail; one in flight finishes
    assign take = (state_reg == ST_IDLE) && CORE_REQ && !ready_reg &&
                  !POWER_FAIL && !sig_pend_reg;

    fmag_guard #(
        .ADDR_W   (ADDR_W)
    ) u_guard (
        .addr     (CORE_ADDR),
        .is_write (CORE_WE),
        .is_fetch (CORE_FETCH),
        .bound1   (bound1_reg),
        .bound2   (bound2_reg),
        .classes  (class_reg),
        .enable   (gen_reg),
        .allow    (g_allow),
        .seg      (g_seg),
        .boot_hit (g_boot)
    );

    fmag_mem #(
        .AW    (WA),
        .DW    (DATA_W)
    ) u_mem (
        .clk   (MCLK),
        .re    (state_reg == ST_SENSE),
        .we    (state_reg == ST_RESTORE),
        .addr  (addr_reg[ADDR_W-1:1]),
        .wdata (merged),
        .rdata (mem_rdata)
    );

    // Access sequencer: sense destroys, restore always follows
    always @(posedge MCLK) begin
        if (!RSTN) begin
            state_reg    <= ST_WAIT;
            wcnt_reg     <= WAIT_MIN3;
            addr_reg     <= `FMAG_SIG_ADDR;
            wdata_reg    <= {DATA_W{1'b0}};
            wmask_reg    <= {DATA_W{1'b0}};
            rdata_reg    <= {DATA_W{1'b0}};
            ready_reg    <= 1'b0;
            err_reg      <= 1'b0;
            sig_pend_reg <= 1'b1;
        end else begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (take) begin
                        if (!g_allow) begin
                            ready_reg <= 1'b1;
                            err_reg   <= 1'b1;
                        end else begin
                            // No unlock or erase step before use
                            addr_reg  <= CORE_ADDR;
                            wdata_reg <= CORE_WDATA;
                            wmask_reg <= CORE_WE ? CORE_WMASK :
                                         {DATA_W{1'b0}};
                            wcnt_reg  <= wait_eff;
                            state_reg <= (wait_eff == 3'h0) ? ST_SENSE :
                                         ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (wcnt_reg <= 3'h1) begin
                        state_reg <= ST_SENSE;
                    end else begin
                        wcnt_reg <= wcnt_reg - 3'h1;
                    end
                end
                ST_SENSE: begin
                    state_reg <= ST_RESTORE;
                end
                ST_RESTORE: begin
                    // Unconditional exit: a restore is never cut short
                    state_reg <= ST_IDLE;
                    if (sig_pend_reg) begin
                        sig_pend_reg <= 1'b0;
                    end else begin
                        rdata_reg <= mem_rdata;
                        ready_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Boot decision after the signature word has been sensed
    always @(posedge MCLK) begin
        if (!RSTN) begin
            boot_req_reg  <= 1'b0;
            boot_skip_reg <= 1'b0;
            i2c_reg       <= 1'b0;
        end else if (sig_pend_reg && state_reg == ST_RESTORE) begin
            boot_req_reg  <= BOOT_ENTRY;
            boot_skip_reg <= (mem_rdata == `FMAG_SIG_VALUE);
            i2c_reg       <= BOOT_IF_I2C;
        end
    end

    assign BOOT_ACTIVE  = boot_req_reg && !boot_skip_reg;
    assign BOOT_UART_EN = BOOT_ACTIVE && !i2c_reg;
    assign BOOT_I2C_EN  = BOOT_ACTIVE && i2c_reg;

    // APB decode
    assign apb_wr       = PSEL && PENABLE && PWRITE;
    assign apb_setup_rd = PSEL && !PENABLE && !PWRITE;
    assign mapped = (PADDR == `FMAG_REG_CTRL)   ||
                    (PADDR == `FMAG_REG_BOUND1) ||
                    (PADDR == `FMAG_REG_BOUND2) ||
                    (PADDR == `FMAG_REG_GCFG)   ||
                    (PADDR == `FMAG_REG_STATUS);
    assign key_ok = PWDATA[`FMAG_KEY_MSB:`FMAG_KEY_LSB] == `FMAG_KEY_WR;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA  = prdata_reg;

    // Configuration registers
    always @(posedge MCLK) begin
        if (!RSTN) begin
            wait_reg   <= WAIT_MIN3;
            bound1_reg <= `FMAG_BOUND_RST;
            bound2_reg <= `FMAG_BOUND_RST;
            class_reg  <= `FMAG_GCFG_RST;
            gen_reg    <= 1'b0;
        end else if (apb_wr) begin
            case (PADDR)
                `FMAG_REG_CTRL: begin
                    if (key_ok) begin
                        wait_reg <= PWDATA[`FMAG_WAIT_MSB:`FMAG_WAIT_LSB];
                    end
                end
                `FMAG_REG_BOUND1: begin
                    bound1_reg <= PWDATA[3:0];
                end
                `FMAG_REG_BOUND2: begin
                    bound2_reg <= PWDATA[3:0];
                end
                `FMAG_REG_GCFG: begin
                    class_reg <= PWDATA[5:0];
                    gen_reg   <= PWDATA[`FMAG_GCFG_EN_BIT];
                end
                default: begin
                    gen_reg <= gen_reg;
                end
            endcase
        end
    end

    // Sticky flags: a new event beats a same-cycle clear
    always @* begin
        flag_next = flag_reg;
        if (apb_wr && PADDR == `FMAG_REG_STATUS) begin
            flag_next = flag_reg & ~PWDATA[4:0];
        end
        if (take && !g_allow) begin
            if (g_boot && CORE_WE) begin
                flag_next[`FMAG_ST_BOOTV] = 1'b1;
            end else begin
                flag_next[g_seg] = 1'b1;
            end
        end
        if (apb_wr && PADDR == `FMAG_REG_CTRL && !key_ok) begin
            flag_next[`FMAG_ST_KEYV] = 1'b1;
        end
    end

    always @(posedge MCLK) begin
        if (!RSTN) begin
            flag_reg  <= 5'h00;
            pfail_reg <= 1'b0;
        end else begin
            flag_reg  <= flag_next;
            pfail_reg <= POWER_FAIL;
        end
    end

    // Read mux, loaded in the setup phase so data stand at the access edge
    always @* begin
        rd_mux = 32'h00000000;
        case (PADDR)
            `FMAG_REG_CTRL: begin
                rd_mux[`FMAG_KEY_MSB:`FMAG_KEY_LSB] = `FMAG_KEY_RD;
                rd_mux[`FMAG_WAIT_MSB:`FMAG_WAIT_LSB] = wait_reg;
            end
            `FMAG_REG_BOUND1: begin
                rd_mux[3:0] = bound1_reg;
            end
            `FMAG_REG_BOUND2: begin
                rd_mux[3:0] = bound2_reg;
            end
            `FMAG_REG_GCFG: begin
                rd_mux[5:0] = class_reg;
                rd_mux[`FMAG_GCFG_EN_BIT] = gen_reg;
            end
            `FMAG_REG_STATUS: begin
                rd_mux[4:0] = flag_reg;
                rd_mux[`FMAG_ST_BUSY] = (state_reg != ST_IDLE);
                rd_mux[`FMAG_ST_PFAIL] = pfail_reg;
                rd_mux[`FMAG_ST_BOOTACT] = BOOT_ACTIVE;
                rd_mux[`FMAG_ST_BOOTSKIP] = boot_skip_reg;
                rd_mux[`FMAG_ST_I2C] = i2c_reg;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always @(posedge MCLK) begin
        if (!RSTN) begin
            prdata_reg <= 32'h00000000;
        end else if (apb_setup_rd) begin
            prdata_reg <= rd_mux;
        end
    end

    assign CORE_RDATA = rdata_reg;
    assign CORE_READY = ready_reg;
    assign CORE_ERR   = err_reg;
endmodule // fmag_ctrl

/* File: fmag_defines.vh */
// Constants for the ferroelectric array controller: register map,
// field positions, reset values, timing figures.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FMAG_DEFINES_VH
`define FMAG_DEFINES_VH

// Register byte offsets on the APB slave
`define FMAG_REG_CTRL       8'h00
`define FMAG_REG_BOUND1     8'h04
`define FMAG_REG_BOUND2     8'h08
`define FMAG_REG_GCFG       8'h0c
`define FMAG_REG_STATUS     8'h10

// memory_control_word fields
`define FMAG_KEY_MSB        15
`define FMAG_KEY_LSB        8
`define FMAG_KEY_WR         8'ha5
`define FMAG_KEY_RD         8'h96
`define FMAG_WAIT_MSB       2
`define FMAG_WAIT_LSB       0

// Guard configuration fields
`define FMAG_GCFG_EN_BIT    8
`define FMAG_CLS_RO         2'h0
`define FMAG_CLS_RW         2'h1
`define FMAG_CLS_RX         2'h2
`define FMAG_GCFG_RST       6'h15
`define FMAG_BOUND_RST      4'h0

// Status bits
`define FMAG_ST_SEG0        0
`define FMAG_ST_BOOTV       3
`define FMAG_ST_KEYV        4
`define FMAG_ST_BUSY        8
`define FMAG_ST_PFAIL       9
`define FMAG_ST_BOOTACT     10
`define FMAG_ST_BOOTSKIP    11
`define FMAG_ST_I2C         12

// Timing: main clock and array access limit, in kHz
`define FMAG_CLK_KHZ        20000
`define FMAG_ARRAY_KHZ      8000

// Array layout
`define FMAG_BLOCK_LSB      12
`define FMAG_BOOT_LO        16'h1000
`define FMAG_BOOT_HI        16'h17ff
`define FMAG_SIG_ADDR       16'hff80
`define FMAG_SIG_VALUE      16'h5555

`endif

/* File: fmag_mem.v */
// Ferroelectric array model: one word per address, registered read.
// Assumes the controller never reads and writes in the same cycle.
module fmag_mem #(
    parameter AW = 15,
    parameter DW = 16
) (
    // Clock
    input  wire          clk,
    // Access
    input  wire          re,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] cells [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            cells[addr] <= wdata;
        end
        if (re) begin
            rdata <= cells[addr];
        end
    end
endmodule // fmag_mem

/* File: fmag_guard.v */
// Region guard: classifies an access by 4 KB block and segment class.
// Assumes bounds are block indices and the access fields are stable.
`include "fmag_defines.vh"
module fmag_guard #(
    parameter ADDR_W = 16
) (
    // Access under test
    input  wire [ADDR_W-1:0] addr,
    input  wire              is_write,
    input  wire              is_fetch,
    // Configuration
    input  wire [3:0]        bound1,
    input  wire [3:0]        bound2,
    input  wire [5:0]        classes,
    input  wire              enable,
    // Verdict
    output reg               allow,
    output reg  [1:0]        seg,
    output wire              boot_hit
);
    wire [3:0] blk;
    reg  [1:0] cls;

    assign blk = addr[`FMAG_BLOCK_LSB+3:`FMAG_BLOCK_LSB];
    assign boot_hit = (addr >= `FMAG_BOOT_LO) && (addr <= `FMAG_BOOT_HI);

    always @* begin
        if (blk < bound1) begin
            seg = 2'h0;
        end else if (blk < bound2) begin
            seg = 2'h1;
        end else begin
            seg = 2'h2;
        end
        cls = classes[seg*2 +: 2];
        allow = 1'b1;
        if (is_write && boot_hit) begin
            allow = 1'b0;
        end else if (enable && is_write && cls != `FMAG_CLS_RW) begin
            allow = 1'b0;
        end else if (enable && is_fetch && cls != `FMAG_CLS_RX) begin
            allow = 1'b0;
        end
    end
endmodule // fmag_guard

/* File: fmag_ctrl_sva.sv */
// Checker for the core port and boot outputs of the array controller.
// Assumes it is bound onto fmag_ctrl and sees only its ports.
module fmag_ctrl_sva #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input wire              MCLK,
    input wire              RSTN,
    // Core port
    input wire              CORE_REQ,
    input wire              CORE_WE,
    input wire [ADDR_W-1:0] CORE_ADDR,
    input wire              CORE_READY,
    input wire              CORE_ERR,
    // System
    input wire              POWER_FAIL,
    input wire              BOOT_IF_I2C,
    input wire              BOOT_ACTIVE,
    input wire              BOOT_UART_EN,
    input wire              BOOT_I2C_EN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    wire boot_wr = CORE_WE && CORE_ADDR >= 16'h1000
                   && CORE_ADDR <= 16'h17ff;
    sequence s_refuse;
        CORE_READY && CORE_ERR;
    endsequence
    sequence s_boot_req;
        $rose(CORE_REQ) && boot_wr && !POWER_FAIL;
    endsequence
    property p_ready_pulse;
        CORE_READY |=> !CORE_READY;
    endproperty
    property p_err_ready;
        CORE_ERR |-> CORE_READY;
    endproperty
    // Wait states at 20 MHz keep any granted access at least five long
    property p_latency;
        CORE_READY && !CORE_ERR |-> $past(CORE_REQ, 4);
    endproperty
    property p_boot_win;
        s_boot_req |-> ##[1:8] s_refuse;
    endproperty
    property p_boot_ready;
        CORE_READY && CORE_REQ && boot_wr |-> CORE_ERR;
    endproperty
    property p_pf_hold;
        POWER_FAIL [*8] |-> !CORE_READY;
    endproperty
    property p_boot_one;
        BOOT_ACTIVE == (BOOT_UART_EN || BOOT_I2C_EN)
            && !(BOOT_UART_EN && BOOT_I2C_EN);
    endproperty
    property p_boot_strap;
        BOOT_ACTIVE |-> BOOT_I2C_EN == BOOT_IF_I2C;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held past one cycle");
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    a_latency: assert property (p_latency)
        else $error("access answered without wait states");
    a_boot_win: assert property (p_boot_win)
        else $error("boot window write not refused in time");
    a_boot_ready: assert property (p_boot_ready)
        else $error("boot window write granted");
    a_pf_hold: assert property (p_pf_hold)
        else $error("access started during power fail");
    a_boot_one: assert property (p_boot_one)
        else $error("boot interface enables inconsistent");
    a_boot_strap: assert property (p_boot_strap)
        else $error("boot interface differs from strap");
endmodule // fmag_ctrl_sva

bind fmag_ctrl fmag_ctrl_sva #(.ADDR_W(ADDR_W)) fmag_ctrl_sva_i (
    .MCLK, .RSTN, .CORE_REQ, .CORE_WE, .CORE_ADDR, .CORE_READY,
    .CORE_ERR, .POWER_FAIL, .BOOT_IF_I2C, .BOOT_ACTIVE,
    .BOOT_UART_EN, .BOOT_I2C_EN
);

/* File: fmag_core_model.sv */
// Core model: one array access at a time on the core port.
// Assumes the bench calls access() and the controller pulses ready.
module fmag_core_model (
    // Clock
    input  wire         mclk,
    // Answer
    input  wire         ready,
    input  wire         err,
    input  wire  [15:0] rdata,
    // Request
    output logic        req,
    output logic        we,
    output logic        fetch,
    output logic [15:0] addr,
    output logic [15:0] wdata,
    output logic [15:0] wmask
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req   = 1'b0;
        we    = 1'b0;
        fetch = 1'b0;
        addr  = 16'hffff;
        wdata = 16'hffff;
        wmask = 16'hffff;
    end
    task automatic access(input logic w, input logic f,
                          input logic [15:0] a, input logic [15:0] d,
                          input logic [15:0] m, output logic [15:0] rd,
                          output logic e, output int n);
        n = 0;
        @(posedge mclk);
        req   <= 1'b1; // Straight in, no unlock step
        we    <= w;
        fetch <= f;
        addr  <= a;
        wdata <= d;
        wmask <= m; // Per-bit mask
        do begin
            @(posedge mclk);
            n++;
        end while (ready !== 1'b1);
        rd = rdata;
        e  = err;
        // Released lines show the inverse, never the last value
        req   <= 1'b0;
        we    <= ~w;
        fetch <= ~f;
        addr  <= ~a;
        wdata <= ~d;
        wmask <= ~m;
    endtask
endmodule // fmag_core_model

/* File: fmag_ctrl_bench.sv */
// Bench: APB register tasks and core accesses with expected values.
// Assumes fmag_ctrl with the core model on its core port.
`include "fmag_defines.vh"
module fmag_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WMIN = (`FMAG_CLK_KHZ + `FMAG_ARRAY_KHZ - 1)
                          / `FMAG_ARRAY_KHZ - 1;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pf = 1'b0;
    logic        boot_entry = 1'b0;
    logic        boot_i2c = 1'b1;
    wire  [31:0] prdata;
    wire         pready, pslverr, req, we, fetch, ready, err;
    wire         boot_act, uart_en, i2c_en;
    wire  [15:0] addr, wdata, wmask, rdata;
    logic [31:0] rdv;
    logic        errv, cerr;
    logic [15:0] crd;
    int          clat, lat_rd;
    int          cycles = 0;
    int          failures = 0;
    int          num_checks = 0;

    always #25 mclk = ~mclk;

    fmag_ctrl fmag_ctrl_i (
        .MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CORE_REQ(req), .CORE_WE(we), .CORE_FETCH(fetch),
        .CORE_ADDR(addr), .CORE_WDATA(wdata), .CORE_WMASK(wmask),
        .CORE_RDATA(rdata), .CORE_READY(ready), .CORE_ERR(err),
        .POWER_FAIL(pf), .BOOT_ENTRY(boot_entry),
        .BOOT_IF_I2C(boot_i2c), .BOOT_ACTIVE(boot_act),
        .BOOT_UART_EN(uart_en), .BOOT_I2C_EN(i2c_en)
    );
    fmag_core_model fmag_core_model_i (
        .mclk(mclk), .ready(ready), .err(err), .rdata(rdata),
        .req(req), .we(we), .fetch(fetch), .addr(addr),
        .wdata(wdata), .wmask(wmask)
    );

    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic stat(input logic [4:0] e);
        apb(1'b0, `FMAG_REG_STATUS, 32'h0);
        chk(rdv & 32'h1f, {27'h0, e});
        apb(1'b1, `FMAG_REG_STATUS, 32'h1f);
    endtask
    task automatic mem(input logic w, input logic f, input logic [15:0] a,
                       input logic [15:0] d, input logic [15:0] m);
        fmag_core_model_i.access(w, f, a, d, m, crd, cerr, clat);
    endtask
    task automatic do_reset(input logic entry, input logic i2c);
        @(posedge mclk);
        rstn       <= 1'b0;
        boot_entry <= entry;
        boot_i2c   <= i2c;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        do_reset(1'b0, 1'b1);
        rdc(`FMAG_REG_CTRL, {16'h0, `FMAG_KEY_RD, 8'(WMIN)});
        rdc(`FMAG_REG_BOUND2, 32'h0);
        rdc(`FMAG_REG_GCFG, 32'h15);
        apb(1'b0, 8'h14, 32'h0);
        chk({rdv[30:0], errv}, 32'h1);
        apb(1'b1, `FMAG_REG_CTRL, 32'h5);
        rdc(`FMAG_REG_CTRL, {16'h0, `FMAG_KEY_RD, 8'(WMIN)});
        stat(5'h10);
        mem(1'b1, 1'b0, 16'h2000, 16'h1234, 16'hffff);
        mem(1'b1, 1'b0, 16'h2002, 16'hbeef, 16'hffff);
        mem(1'b1, 1'b0, 16'h2000, 16'h00a0, 16'h00f0);
        chk({cerr, crd}, 32'h1234);
        mem(1'b0, 1'b0, 16'h2000, 16'h0, 16'h0);
        lat_rd = clat;
        chk(crd, 32'h12a4);
        mem(1'b0, 1'b0, 16'h2000, 16'h0, 16'h0);
        chk(crd, 32'h12a4);
        mem(1'b0, 1'b0, 16'h2002, 16'h0, 16'h0);
        chk(crd, 32'hbeef);
        apb(1'b1, `FMAG_REG_CTRL, 32'ha505);
        rdc(`FMAG_REG_CTRL, {16'h0, `FMAG_KEY_RD, 8'h05});
        mem(1'b0, 1'b0, 16'h2000, 16'h0, 16'h0);
        chk(32'(clat - lat_rd), 32'h3);
        apb(1'b1, `FMAG_REG_CTRL, 32'ha500);
        rdc(`FMAG_REG_CTRL, {16'h0, `FMAG_KEY_RD, 8'h00});
        mem(1'b0, 1'b0, 16'h2000, 16'h0, 16'h0);
        chk(32'(clat), 32'(lat_rd));
        apb(1'b1, `FMAG_REG_CTRL, 32'ha502); // Wait first
        mem(1'b1, 1'b0, 16'h1000, 16'h0, 16'hffff);
        chk(32'(lat_rd - clat), 32'(WMIN + 2));
        chk(cerr, 1'b1);
        mem(1'b1, 1'b0, 16'h17fe, 16'h0, 16'hffff);
        chk(cerr, 1'b1);
        stat(5'h08);
        mem(1'b1, 1'b0, 16'h1800, 16'h0, 16'h0);
        chk(cerr, 1'b0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `FMAG_REG_GCFG, 32'(32'h100 | (c << 4)));
            mem(1'b1, 1'b0, 16'h4000, 16'h0, 16'h0);
            chk(cerr, c != 1);
            mem(1'b0, 1'b1, 16'h4000, 16'h0, 16'h0);
            chk(cerr, c != 2);
            stat(5'h04);
        end
        apb(1'b1, `FMAG_REG_BOUND1, 32'h2);
        apb(1'b1, `FMAG_REG_BOUND2, 32'h4);
        apb(1'b1, `FMAG_REG_GCFG, 32'h111);
        mem(1'b1, 1'b0, 16'h2000, 16'h0, 16'hffff);
        chk(cerr, 1'b1);
        mem(1'b1, 1'b0, 16'h1ffe, 16'h0, 16'h0);
        chk(cerr, 1'b0);
        stat(5'h02);
        mem(1'b0, 1'b0, 16'h2000, 16'h0, 16'h0);
        chk({cerr, crd}, 32'h12a4);
        apb(1'b1, `FMAG_REG_BOUND1, 32'h3);
        mem(1'b1, 1'b0, 16'h2000, 16'h0, 16'h0);
        chk(cerr, 1'b0);
        fork
            mem(1'b0, 1'b0, 16'h2002, 16'h0, 16'h0);
            begin
                repeat (2) @(posedge mclk);
                pf <= 1'b1;
            end
        join
        chk({cerr, crd}, 32'hbeef);
        apb(1'b0, `FMAG_REG_STATUS, 32'h0);
        chk(rdv & 32'h300, 32'h200);
        fork
            mem(1'b0, 1'b0, 16'h2002, 16'h0, 16'h0);
            begin
                repeat (12) @(negedge mclk) chk(ready, 1'b0);
                @(posedge mclk);
                pf <= 1'b0;
            end
        join
        chk({cerr, crd}, 32'hbeef);
        mem(1'b1, 1'b0, `FMAG_SIG_ADDR, `FMAG_SIG_VALUE, 16'hffff);
        do_reset(1'b1, 1'b1);
        chk({boot_act, uart_en, i2c_en}, 3'b000);
        rdc(`FMAG_REG_STATUS, 32'h1800);
        mem(1'b1, 1'b0, `FMAG_SIG_ADDR, 16'h0, 16'hffff);
        do_reset(1'b1, 1'b1);
        chk({boot_act, uart_en, i2c_en}, 3'b101);
        rdc(`FMAG_REG_STATUS, 32'h1400);
        do_reset(1'b1, 1'b0);
        chk({boot_act, uart_en, i2c_en}, 3'b110);
        rdc(`FMAG_REG_STATUS, 32'h0400);
        summarize();
    end
endmodule // fmag_ctrl_bench
